// ===== rx_cfg_consts.vh
// constants for the receiver configuration command decoder
`ifndef RX_CFG_CONSTS_VH
`define RX_CFG_CONSTS_VH
// frame length and command prefixes
`define FRAME_BITS        5'd16
`define PFX_CFG           3'b100
`define PFX_FREQ          4'b1010
`define PFX_RX            8'hC0
`define PFX_SYNC          8'hC1
`define PFX_WAKE          3'b111
`define PFX_WAKE_X        8'hC3
// power-on values of the command words
`define RST_CFG           16'h928A
`define RST_FREQ          16'hAD57
`define RST_RX            16'hC080
`define RST_SYNC          16'hC1D4
`define RST_WAKE          16'hE196
`define RST_WAKE_X        16'hC300
// field positions in the configuration word
`define CFG_BAND_HI       12
`define CFG_BAND_LO       11
`define CFG_BATT          10
`define CFG_WAKE          9
`define CFG_XTAL          8
`define CFG_LOAD_HI       7
`define CFG_LOAD_LO       4
`define CFG_BW_HI         3
`define CFG_BW_LO         1
`define CFG_CLKDIS        0
// band codes
`define BAND_433          2'b01
`define BAND_868          2'b10
`define BAND_915          2'b11
// synthesizer constants per band
`define SYN_N_433         4'h4
`define SYN_N_HI          4'h8
`define SYN_C_LO          4'hA
`define SYN_C_915         4'hB
// frequency word limits
`define FREQ_MIN          12'h060
`define FREQ_MAX          12'hF3F
// receiver word fields
`define RX_VDI_HI         7
`define RX_VDI_LO         6
`define RX_GAIN_HI        5
`define RX_GAIN_LO        4
`define RX_RSSI_HI        3
`define RX_RSSI_LO        1
`define RX_EN             0
`define VDI_STRENGTH      2'b00
`define VDI_QUALITY       2'b01
`define VDI_LOCK          2'b10
// rssi threshold arithmetic in dBm
`define RSSI_BASE_DBM     8'h99
`define RSSI_STEP_DB      8'h06
// fixed upper sync byte
`define SYNC_HIGH_BYTE    8'h2D
// wake-up timer fields
`define WK_EXP_HI         11
`define WK_EXP_LO         8
`define WK_MLO_HI         7
`define WK_MHI_HI         5
`define WK_OFS_HI         7
`define WK_OFS_LO         6
`define WK_SUB_SHIFT      5'd3
// clock tail lengths in output clock pulses
`define TAIL_LONG         10'd512
`define TAIL_SHORT        10'd128
// wake-up sub tick: one eighth of a millisecond
`define WK_SUB_TICK_NS    125000
`define CLK_PERIOD_NS     25
`endif

// ===== rx_config_command_decoder.v
// serial command decoder and setting registers of the fsk receiver
`timescale 1ns/100ps
`default_nettype none
`include "rx_cfg_consts.vh"

module rx_config_command_decoder #(
    parameter SUB_TICK_CYCLES = `WK_SUB_TICK_NS / `CLK_PERIOD_NS
) (
    // clock, reset, enable
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        ce_i,
    // serial control port pins
    input  wire        serial_clock_i,
    input  wire        serial_data_i,
    input  wire        serial_select_low_i,
    // same-domain receiver status and mode inputs
    input  wire        digital_signal_strength_i,
    input  wire        data_quality_flag_i,
    input  wire        clock_lock_i,
    input  wire        duty_cycle_mode_i,
    input  wire        slow_clock_keep_i,
    input  wire        clock_tail_long_i,
    input  wire        clk_out_pulse_i,
    // configuration settings
    output wire [1:0]  band_select_o,
    output wire        low_battery_detector_enable_o,
    output wire        wakeup_timer_enable_o,
    output wire        crystal_keep_on_o,
    output wire [3:0]  crystal_load_cap_o,
    output wire [2:0]  baseband_bw_select_o,
    output wire        clock_output_disable_o,
    // synthesizer
    output wire [11:0] synth_freq_word_o,
    output reg  [3:0]  synth_n_o,
    output reg  [3:0]  synth_c_o,
    // receiver settings
    output wire [1:0]  valid_indicator_source_o,
    output wire [1:0]  lna_gain_select_o,
    output wire [2:0]  rssi_threshold_select_o,
    output reg  [7:0]  rssi_threshold_dbm_o,
    output wire        receiver_enable_o,
    output reg         valid_data_flag_o,
    // sync pattern and wake-up timer
    output wire [15:0] sync_pattern_o,
    output wire [13:0] wakeup_mantissa_o,
    output wire [3:0]  wakeup_exponent_o,
    output wire [1:0]  wakeup_exponent_offset_o,
    // oscillators and interrupt
    output reg         slow_osc_on_o,
    output reg         crystal_on_o,
    output reg         wakeup_flag_o,
    output reg         interrupt_request_low_o
);

    // command word holding registers
    reg [15:0] cfg_reg;
    reg [15:0] freq_reg;
    reg [15:0] rx_reg;
    reg [15:0] sync_reg;
    reg [15:0] wake_reg;
    reg [15:0] wake_x_reg;

    // pin synchronisers and shift state
    reg [2:0]  sck_sync_reg;
    reg [1:0]  sdi_sync_reg;
    reg [2:0]  sel_sync_reg;
    reg [15:0] shift_reg;
    reg [4:0]  bit_cnt_reg;
    reg        first_bit_reg;

    // wake-up timer and clock tail state
    reg [15:0] sub_cnt_reg;
    reg [31:0] period_cnt_reg;
    reg [9:0]  tail_cnt_reg;

    wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
    wire sel_low  = ~sel_sync_reg[1];
    wire sel_rise = sel_sync_reg[1] & ~sel_sync_reg[2];

    // frame ends: full word, or a status read starting with zero
    wire frame_done  = sel_rise & (bit_cnt_reg == `FRAME_BITS);
    wire status_read = sel_rise & (bit_cnt_reg != 5'd0) & ~first_bit_reg;

    wire wr_cfg    = frame_done & (shift_reg[15:13] == `PFX_CFG);
    wire wr_freq   = frame_done & (shift_reg[15:12] == `PFX_FREQ);
    wire wr_rx     = frame_done & (shift_reg[15:8] == `PFX_RX);
    wire wr_sync   = frame_done & (shift_reg[15:8] == `PFX_SYNC);
    wire wr_wake   = frame_done & (shift_reg[15:13] == `PFX_WAKE);
    wire wr_wake_x = frame_done & (shift_reg[15:8] == `PFX_WAKE_X);

    // range check on the frequency word
    wire freq_ok = (shift_reg[11:0] >= `FREQ_MIN) &
                   (shift_reg[11:0] <= `FREQ_MAX);

    // keep-on cleared with clock output on starts the tail
    wire tail_start = wr_cfg & cfg_reg[`CFG_XTAL] &
                      ~shift_reg[`CFG_XTAL] & ~shift_reg[`CFG_CLKDIS];
    // tail length chosen by the long/short setting
    wire [9:0] tail_len = clock_tail_long_i ? `TAIL_LONG : `TAIL_SHORT;

    // mantissa and exponents gathered from two words
    wire [13:0] mant = {wake_x_reg[`WK_MHI_HI:0], wake_reg[`WK_MLO_HI:0]};
    wire [3:0]  rexp = wake_reg[`WK_EXP_HI:`WK_EXP_LO];
    wire [1:0]  cexp = wake_x_reg[`WK_OFS_HI:`WK_OFS_LO];
    // period in eighth-ms ticks: M shifted by R-C+3
    wire [4:0]  shamt = {1'b0, rexp} + `WK_SUB_SHIFT - {3'b000, cexp};
    wire [31:0] period_ticks = {18'h00000, mant} << shamt;

    wire sub_tick = (sub_cnt_reg == SUB_TICK_CYCLES[15:0] - 16'h0001);
    wire wk_en    = cfg_reg[`CFG_WAKE];
    wire wake_event = wk_en & sub_tick & (period_ticks != 32'h00000000) &
                      (period_cnt_reg >= period_ticks - 32'h00000001);

    // effective threshold: base + 6*code + gain step (-6 each)
    wire [7:0] rssi_eff = `RSSI_BASE_DBM +
        `RSSI_STEP_DB * {5'h00, rx_reg[`RX_RSSI_HI:`RX_RSSI_LO]} -
        `RSSI_STEP_DB * {6'h00, rx_reg[`RX_GAIN_HI:`RX_GAIN_LO]};

    // synchronise the serial pins before any use
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_sync_reg <= 3'h0;
            sdi_sync_reg <= 2'h0;
            sel_sync_reg <= 3'h7;
        end else if (ce_i) begin
            sck_sync_reg <= {sck_sync_reg[1:0], serial_clock_i};
            sdi_sync_reg <= {sdi_sync_reg[0], serial_data_i};
            sel_sync_reg <= {sel_sync_reg[1:0], serial_select_low_i};
        end
    end

    // shift on rising serial clock while select is low
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg     <= 16'h0000;
            bit_cnt_reg   <= 5'h00;
            first_bit_reg <= 1'b1;
        end else if (ce_i) begin
            if (!sel_low) begin
                bit_cnt_reg <= 5'h00;
            end else if (sck_rise) begin
                shift_reg <= {shift_reg[14:0], sdi_sync_reg[1]};
                if (bit_cnt_reg == 5'h00) begin
                    first_bit_reg <= sdi_sync_reg[1];
                end
                // longer frames saturate and are dropped at the end
                if (bit_cnt_reg != 5'h1F) begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                end
            end
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_reg    <= `RST_CFG;
            freq_reg   <= `RST_FREQ;
            rx_reg     <= `RST_RX;
            sync_reg   <= `RST_SYNC;
            wake_reg   <= `RST_WAKE;
            wake_x_reg <= `RST_WAKE_X;
        end else if (ce_i) begin
            if (wr_cfg) begin
                cfg_reg <= shift_reg;
            end
            // out-of-range word leaves the old value
            if (wr_freq && freq_ok) begin
                freq_reg <= shift_reg;
            end
            if (wr_rx) begin
                rx_reg <= shift_reg;
            end
            if (wr_sync) begin
                sync_reg <= shift_reg;
            end
            if (wr_wake) begin
                wake_reg <= shift_reg;
            end
            if (wr_wake_x) begin
                wake_x_reg <= shift_reg;
            end
        end
    end

    // wake-up timer counts only while enabled
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sub_cnt_reg    <= 16'h0000;
            period_cnt_reg <= 32'h00000000;
        end else if (ce_i) begin
            // a new period setting restarts the count cleanly
            if (!wk_en || wr_wake || wr_wake_x) begin
                sub_cnt_reg    <= 16'h0000;
                period_cnt_reg <= 32'h00000000;
            end else if (sub_tick) begin
                sub_cnt_reg <= 16'h0000;
                if (wake_event) begin
                    period_cnt_reg <= 32'h00000000;
                end else begin
                    period_cnt_reg <= period_cnt_reg + 32'h00000001;
                end
            end else begin
                sub_cnt_reg <= sub_cnt_reg + 16'h0001;
            end
        end
    end

    // wake flag drives the active-low request; set beats clear
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wakeup_flag_o           <= 1'b0;
            interrupt_request_low_o <= 1'b1;
        end else if (ce_i) begin
            if (wake_event) begin
                wakeup_flag_o           <= 1'b1;
                interrupt_request_low_o <= 1'b0;
            end else if (status_read) begin
                wakeup_flag_o           <= 1'b0;
                interrupt_request_low_o <= 1'b1;
            end
        end
    end

    // clock tail counts output clock pulses down
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tail_cnt_reg <= 10'h000;
        end else if (ce_i) begin
            if (tail_start) begin
                tail_cnt_reg <= tail_len;
            end else if (wr_cfg && shift_reg[`CFG_XTAL]) begin
                tail_cnt_reg <= 10'h000; // keep-on again, tail not needed
            end else if (tail_cnt_reg != 10'h000 && clk_out_pulse_i) begin
                tail_cnt_reg <= tail_cnt_reg - 10'h001;
            end
        end
    end

    // registered derived outputs
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            crystal_on_o         <= 1'b0;
            slow_osc_on_o        <= 1'b0;
            valid_data_flag_o    <= 1'b0;
            synth_n_o            <= 4'h0;
            synth_c_o            <= 4'h0;
            rssi_threshold_dbm_o <= 8'h00;
        end else if (ce_i) begin
            // crystal on by keep bit, receiver, or tail
            crystal_on_o <= cfg_reg[`CFG_XTAL] | rx_reg[`RX_EN] |
                            (tail_cnt_reg != 10'h000);
            // slow oscillator request from any of four sources
            slow_osc_on_o <= slow_clock_keep_i | duty_cycle_mode_i |
                             cfg_reg[`CFG_BATT] | cfg_reg[`CFG_WAKE];
            case (rx_reg[`RX_VDI_HI:`RX_VDI_LO])
                `VDI_STRENGTH: valid_data_flag_o <= digital_signal_strength_i;
                `VDI_QUALITY:  valid_data_flag_o <= data_quality_flag_i;
                `VDI_LOCK:     valid_data_flag_o <= clock_lock_i;
                default:       valid_data_flag_o <= 1'b1;
            endcase
            // synthesizer constants from the band, codes
            case (cfg_reg[`CFG_BAND_HI:`CFG_BAND_LO])
                `BAND_433: begin
                    synth_n_o <= `SYN_N_433;
                    synth_c_o <= `SYN_C_LO;
                end
                `BAND_868: begin
                    synth_n_o <= `SYN_N_HI;
                    synth_c_o <= `SYN_C_LO;
                end
                `BAND_915: begin
                    synth_n_o <= `SYN_N_HI;
                    synth_c_o <= `SYN_C_915;
                end
                default: begin
                    synth_n_o <= 4'h0; // reserved band: no synthesis
                    synth_c_o <= 4'h0;
                end
            endcase
            // gain step folded into the threshold
            rssi_threshold_dbm_o <= rssi_eff;
        end
    end

    assign band_select_o = cfg_reg[`CFG_BAND_HI:`CFG_BAND_LO];
    assign low_battery_detector_enable_o = cfg_reg[`CFG_BATT];
    assign wakeup_timer_enable_o = cfg_reg[`CFG_WAKE];
    assign crystal_keep_on_o = cfg_reg[`CFG_XTAL];
    // load code, bandwidth code, clock disable
    assign crystal_load_cap_o = cfg_reg[`CFG_LOAD_HI:`CFG_LOAD_LO];
    assign baseband_bw_select_o = cfg_reg[`CFG_BW_HI:`CFG_BW_LO];
    assign clock_output_disable_o = cfg_reg[`CFG_CLKDIS];
    assign synth_freq_word_o = freq_reg[11:0];
    assign valid_indicator_source_o = rx_reg[`RX_VDI_HI:`RX_VDI_LO];
    assign lna_gain_select_o = rx_reg[`RX_GAIN_HI:`RX_GAIN_LO];
    assign rssi_threshold_select_o = rx_reg[`RX_RSSI_HI:`RX_RSSI_LO];
    assign receiver_enable_o = rx_reg[`RX_EN];
    // fixed upper byte with programmable lower byte
    assign sync_pattern_o = {`SYNC_HIGH_BYTE, sync_reg[7:0]};
    assign wakeup_mantissa_o = mant;
    assign wakeup_exponent_o = rexp;
    assign wakeup_exponent_offset_o = cexp;

endmodule
`default_nettype wire

// ===== rx_cfg_monitor.sv
// concurrent checks on the decoder ports
`timescale 1ns/100ps
`default_nettype none
module rx_cfg_monitor (
    // clock, reset and watched ports
    input wire logic        clk_i, rst_n_i, clock_lock_i,
    input wire logic        digital_signal_strength_i, data_quality_flag_i,
    input wire logic        slow_clock_keep_i, duty_cycle_mode_i,
    input wire logic [1:0]  band_select_o, valid_indicator_source_o,
    input wire logic [1:0]  lna_gain_select_o,
    input wire logic [2:0]  rssi_threshold_select_o,
    input wire logic [3:0]  synth_n_o, synth_c_o,
    input wire logic [7:0]  rssi_threshold_dbm_o,
    input wire logic [11:0] synth_freq_word_o,
    input wire logic [15:0] sync_pattern_o,
    input wire logic        valid_data_flag_o, receiver_enable_o,
    input wire logic        low_battery_detector_enable_o,
    input wire logic        wakeup_timer_enable_o, slow_osc_on_o,
    input wire logic        crystal_on_o, crystal_keep_on_o,
    input wire logic        wakeup_flag_o, interrupt_request_low_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // expected derived values, compared one cycle later
    wire [3:0] srcs = {1'b1, clock_lock_i, data_quality_flag_i,
                       digital_signal_strength_i};
    wire [7:0] dbm = 8'h99 + 8'h06 * {5'h0, rssi_threshold_select_o}
                     - 8'h06 * {6'h0, lna_gain_select_o};
    wire [3:0] n_exp = band_select_o == 2'h0 ? 4'h0 :
                       band_select_o == 2'h1 ? 4'h4 : 4'h8;
    wire [3:0] c_exp = band_select_o == 2'h0 ? 4'h0 :
                       band_select_o == 2'h3 ? 4'hB : 4'hA;
    wire slow_req = slow_clock_keep_i | duty_cycle_mode_i |
                    low_battery_detector_enable_o | wakeup_timer_enable_o;
    // band constants
    // no check on the first edge after reset: history is reset-time values
    synth_nc_a: assert property (
        $past(rst_n_i) |-> {synth_n_o, synth_c_o} == $past({n_exp, c_exp}))
        else $error("synth constants differ from band");
    vdi_mux_a: assert property (
        $past(rst_n_i) |->
        valid_data_flag_o == $past(srcs[valid_indicator_source_o]))
        else $error("valid flag not the selected source");
    rssi_sum_a: assert property (
        $past(rst_n_i) |-> rssi_threshold_dbm_o == $past(dbm))
        else $error("rssi threshold wrong");
    sync_high_a: assert property (sync_pattern_o[15:8] == 8'h2D)
        else $error("upper sync byte wrong");
    freq_range_a: assert property ($changed(synth_freq_word_o) |->
        synth_freq_word_o >= 12'h060 && synth_freq_word_o <= 12'hF3F)
        else $error("out of range frequency accepted");
    slow_osc_a: assert property (
        $past(rst_n_i) |-> slow_osc_on_o == $past(slow_req))
        else $error("slow oscillator state wrong");
    crystal_keep_a: assert property (
        crystal_keep_on_o || receiver_enable_o |=> crystal_on_o)
        else $error("crystal off while requested");
    wake_irq_a: assert property (
        $rose(wakeup_flag_o) |-> ##[0:1] !interrupt_request_low_o)
        else $error("no interrupt on wake event");
    wake_stop_a: assert property (
        !wakeup_timer_enable_o [*3] |-> !$rose(wakeup_flag_o))
        else $error("wake event while timer off");
endmodule
bind rx_config_command_decoder rx_cfg_monitor i_rx_cfg_monitor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .clock_lock_i(clock_lock_i),
    .digital_signal_strength_i(digital_signal_strength_i),
    .data_quality_flag_i(data_quality_flag_i),
    .slow_clock_keep_i(slow_clock_keep_i),
    .duty_cycle_mode_i(duty_cycle_mode_i), .band_select_o(band_select_o),
    .valid_indicator_source_o(valid_indicator_source_o),
    .lna_gain_select_o(lna_gain_select_o),
    .rssi_threshold_select_o(rssi_threshold_select_o),
    .synth_n_o(synth_n_o), .synth_c_o(synth_c_o),
    .rssi_threshold_dbm_o(rssi_threshold_dbm_o),
    .synth_freq_word_o(synth_freq_word_o), .sync_pattern_o(sync_pattern_o),
    .valid_data_flag_o(valid_data_flag_o),
    .receiver_enable_o(receiver_enable_o),
    .low_battery_detector_enable_o(low_battery_detector_enable_o),
    .wakeup_timer_enable_o(wakeup_timer_enable_o),
    .slow_osc_on_o(slow_osc_on_o), .crystal_on_o(crystal_on_o),
    .crystal_keep_on_o(crystal_keep_on_o), .wakeup_flag_o(wakeup_flag_o),
    .interrupt_request_low_o(interrupt_request_low_o));
`default_nettype wire

// ===== rx_cfg_host_model.sv
// host model sending command frames on the serial port
`timescale 1ns/100ps
`default_nettype none
module rx_cfg_host_model (
    // pacing clock
    input  wire logic clk_i,
    // serial control pins
    output var  logic sck_o,
    output var  logic sdi_o,
    output var  logic sel_n_o
);
    // idle: link clock stands low, select high
    initial begin
        sck_o = 1'b0;
        sdi_o = 1'b0;
        sel_n_o = 1'b1;
    end
    // frame msb first, 200 ns link clock
    task automatic send(input logic [15:0] w, input int n);
        sel_n_o = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            sdi_o = w[i];
            repeat (4) @(negedge clk_i);
            sck_o = 1'b1;
            repeat (4) @(negedge clk_i);
            sck_o = 1'b0;
        end
        @(negedge clk_i);
        sel_n_o = 1'b1;
        // released line must not keep the last bit
        sdi_o = ~sdi_o;
        repeat (4) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// ===== rx_config_command_decoder_tb.sv
// self-checking bench of the receiver command decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected at %0t got %h exp %h", $time, (a), (e)); end end
module rx_config_command_decoder_tb;
    logic clk_i, rst_n_i, dss, dqf, lock, duty, keep, tl, pulse;
    wire sck, sdi, sel_n, batt, wake, xkeep, dc, en, vdf, sosc, xon;
    wire wflag, irq_n;
    wire [1:0] band, src, gain, wofs;
    wire [2:0] bw, rssi;
    wire [3:0] load, syn_n, syn_c, wexp;
    wire [7:0] dbm;
    wire [11:0] freq;
    wire [13:0] mant;
    wire [15:0] sync;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int t1, t2;
    logic [11:0] fe;
    logic [11:0] ftab [5] = '{12'h060, 12'h05F, 12'hF3F, 12'hF40, 12'h0C8};
    rx_cfg_host_model i_host (.clk_i(clk_i), .sck_o(sck), .sdi_o(sdi),
        .sel_n_o(sel_n));
    rx_config_command_decoder #(.SUB_TICK_CYCLES(4)) i_rx_config_command_decoder (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .serial_clock_i(sck), .serial_data_i(sdi),
        .serial_select_low_i(sel_n), .digital_signal_strength_i(dss),
        .data_quality_flag_i(dqf), .clock_lock_i(lock),
        .duty_cycle_mode_i(duty), .slow_clock_keep_i(keep),
        .clock_tail_long_i(tl), .clk_out_pulse_i(pulse),
        .band_select_o(band), .low_battery_detector_enable_o(batt),
        .wakeup_timer_enable_o(wake), .crystal_keep_on_o(xkeep),
        .crystal_load_cap_o(load), .baseband_bw_select_o(bw),
        .clock_output_disable_o(dc), .synth_freq_word_o(freq),
        .synth_n_o(syn_n), .synth_c_o(syn_c),
        .valid_indicator_source_o(src), .lna_gain_select_o(gain),
        .rssi_threshold_select_o(rssi), .rssi_threshold_dbm_o(dbm),
        .receiver_enable_o(en), .valid_data_flag_o(vdf),
        .sync_pattern_o(sync), .wakeup_mantissa_o(mant),
        .wakeup_exponent_o(wexp), .wakeup_exponent_offset_o(wofs),
        .slow_osc_on_o(sosc), .crystal_on_o(xon), .wakeup_flag_o(wflag),
        .interrupt_request_low_o(irq_n));
    // 40 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // runaway guard, run needs about 7700 cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            report_and_stop;
        end
    end
    // one command, then let decode and derived outputs settle
    task automatic wr(input logic [15:0] w);
        i_host.send(w, 16);
        repeat (8) @(negedge clk_i);
    endtask
    task automatic chk_cfg(input logic [15:0] w);
        `CHK({band, batt, wake, xkeep, load, bw, dc}, w[12:0])
    endtask
    // bounded wait for the wake flag, stamps the cycle seen
    task automatic wait_flag(output int t);
        for (int i = 0; i < 3000 && wflag !== 1'b1; i++) @(negedge clk_i);
        t = cyc;
    endtask
    task automatic pulse_once;
        pulse = 1'b1;
        @(negedge clk_i);
        pulse = 1'b0;
        @(negedge clk_i);
    endtask
    initial begin
        {dss, dqf, lock, duty, keep, tl, pulse} = '0;
        rst_n_i = 1'b0;
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk_cfg(16'h928A);
        `CHK(freq, 12'hD57)
        `CHK({src, gain, rssi, en}, 8'h80)
        `CHK(sync, 16'h2DD4)
        `CHK({mant, wexp, wofs}, {14'h0096, 4'h1, 2'h0})
        $display("test power-on finished");
        for (int b = 0; b < 4; b++) begin
            wr({3'b100, b[1:0], b[0] ? 11'h555 : 11'h2AA});
            chk_cfg({3'b100, b[1:0], b[0] ? 11'h555 : 11'h2AA});
            `CHK(batt, b[0])
            `CHK(wake, !b[0])
            `CHK(xkeep, b[0])
            `CHK(load, b[0] ? 4'h5 : 4'hA)
            `CHK(bw, b[0] ? 3'h2 : 3'h5)
            `CHK(dc, b[0])
            `CHK(syn_n, b == 0 ? 4'h0 : b == 1 ? 4'h4 : 4'h8)
            `CHK(syn_c, b == 0 ? 4'h0 : b == 3 ? 4'hB : 4'hA)
        end
        $display("test config finished");
        fe = 12'hD57;
        foreach (ftab[i]) begin
            wr({4'hA, ftab[i]});
            if (ftab[i] >= 12'h060 && ftab[i] <= 12'hF3F) fe = ftab[i];
            `CHK(freq, fe)
        end
        $display("test frequency finished");
        wr(16'h8803);
        for (int d = 0; d < 4; d++) begin
            wr({8'hC0, d[1:0], d[1:0], 3'(7 - 2 * d), d[0]});
            {lock, dqf, dss} = ~(3'b001 << d);
            repeat (2) @(negedge clk_i);
            `CHK(vdf, d == 3)
            {lock, dqf, dss} = 3'b001 << d;
            repeat (2) @(negedge clk_i);
            `CHK(vdf, 1'b1)
            `CHK(dbm, 8'(-103 + 6 * (7 - 2 * d) - 6 * d))
            `CHK(gain, d[1:0])
            `CHK({xon, wake}, {d[0], 1'b0})
        end
        $display("test receiver finished");
        wr(16'hC1A5);
        `CHK(sync, 16'h2DA5)
        i_host.send(16'hC13C, 15);
        repeat (8) @(negedge clk_i);
        `CHK(sync, 16'h2DA5)
        $display("test sync finished");
        wr(16'hC3C1);
        wr(16'hE20A);
        `CHK({mant, wexp, wofs}, {14'h010A, 4'h2, 2'h3})
        wr(16'hC300);
        wr(16'h8A03);
        wr(16'h0000);
        wait_flag(t1);
        @(negedge clk_i);
        `CHK(irq_n, 1'b0)
        wr(16'h0000);
        `CHK({wflag, irq_n}, 2'b01)
        wait_flag(t2);
        `CHK(t2 - t1, 1280)
        wr(16'h8803);
        wr(16'h0000);
        $display("test wake timer finished");
        // receiver left enabled would hold the crystal on through the tail
        wr(16'hC080);
        `CHK(xon, 1'b0)
        for (int k = 0; k < 2; k++) begin
            tl = k[0];
            wr(16'h8902);
            wr(16'h8802);
            for (int p = 1; p < (k ? 512 : 128); p++) pulse_once;
            `CHK(xon, 1'b1)
            pulse_once;
            repeat (3) @(negedge clk_i);
            `CHK(xon, 1'b0)
        end
        $display("test clock tail finished");
        `CHK({wflag, sosc}, 2'b00)
        for (int i = 0; i < 2; i++) begin
            {duty, keep} = 2'b01 << i;
            repeat (2) @(negedge clk_i);
            `CHK(sosc, 1'b1)
        end
        $display("test slow oscillator finished");
        report_and_stop;
    end
endmodule
`default_nettype wire
